// [verilog/rpd_pkg.sv]
// rotor position detector: register map, field layout, codes
// assumes an 8-bit byte-addressed register port and a single clock
`default_nettype none
package rpd_pkg;

  // ==========================================================
  // bus and register map
  localparam int          RPD_AW          = 13;
  localparam int          RPD_DW          = 8;
  localparam logic [12:0] RPD_OFS_CTRL    = 13'h1FA0;
  localparam logic [12:0] RPD_OFS_CFG     = 13'h1FA1;
  localparam logic [12:0] RPD_OFS_STAT    = 13'h1FA2;
  localparam logic [12:0] RPD_OFS_EXPECT  = 13'h1FA3;
  localparam logic [7:0]  RPD_CFG_RESET   = 8'h00;
  localparam logic [7:0]  RPD_UNMAPPED    = 8'h00;

  // ==========================================================
  // sampling_control bits
  localparam int RPD_B_SW_STOP    = 7;
  localparam int RPD_B_SW_START   = 6;
  localparam int RPD_B_TC_STOP    = 5;
  localparam int RPD_B_TB_START   = 4;
  localparam int RPD_B_INPUT_CNT  = 3;
  localparam int RPD_B_RECOUNT    = 2;
  localparam int RPD_B_DETECT_MD  = 1;

  // ==========================================================
  // sampling_config fields
  localparam int RPD_F_CLK_HI  = 7;
  localparam int RPD_F_CLK_LO  = 6;
  localparam int RPD_F_COND_HI = 5;
  localparam int RPD_F_COND_LO = 4;
  localparam int RPD_F_CNT_HI  = 3;
  localparam int RPD_F_CNT_LO  = 0;

  // ==========================================================
  // detection_status fields
  localparam int RPD_F_PHASE_HI = 5;
  localparam int RPD_F_PHASE_LO = 4;
  localparam int RPD_B_ACTIVE   = 3;
  localparam int RPD_F_SNAP_HI  = 2;
  localparam int RPD_F_SNAP_LO  = 0;

  // ==========================================================
  // codes
  localparam logic [1:0] RPD_CLK_DIV4    = 2'b00;
  localparam logic [1:0] RPD_CLK_DIV8    = 2'b01;
  localparam logic [1:0] RPD_CLK_DIV16   = 2'b10;
  localparam logic [1:0] RPD_CLK_DIV32   = 2'b11;
  localparam logic [1:0] RPD_COND_PWM_ON = 2'b00;
  localparam logic [1:0] RPD_COND_ALWAYS = 2'b01;
  localparam logic [1:0] RPD_COND_LOWER  = 2'b10;
  localparam logic [1:0] RPD_PHASE_OFF   = 2'b01;
  localparam logic [2:0] RPD_MASK_ONE    = 3'h1;
  localparam logic [2:0] RPD_MASK_THREE  = 3'h7;
  localparam logic [3:0] RPD_CNT_ONE     = 4'h1;
  localparam logic [4:0] RPD_DIV4_MASK   = 5'h03;
  localparam logic [4:0] RPD_DIV8_MASK   = 5'h07;
  localparam logic [4:0] RPD_DIV16_MASK  = 5'h0F;
  localparam logic [4:0] RPD_DIV32_MASK  = 5'h1F;

  typedef enum logic {RPD_IDLE, RPD_SAMPLING} rpd_state_t;

endpackage : rpd_pkg
`default_nettype wire

// [verilog/rpd_sample_tick.sv]
// sampling tick generator: one-cycle pulse every 4, 8, 16 or 32 clocks
// assumes the select comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module rpd_sample_tick
  import rpd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic [1:0] clk_sel,
  // tick
  output var  logic       tick
);

  // ==========================================================
  // divider
  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [4:0] mask;

  always_comb begin
    case (clk_sel)
      RPD_CLK_DIV4:  mask = RPD_DIV4_MASK;
      RPD_CLK_DIV8:  mask = RPD_DIV8_MASK;
      RPD_CLK_DIV16: mask = RPD_DIV16_MASK;
      default:       mask = RPD_DIV32_MASK;
    endcase
    div_nxt  = div_r + 5'h01;
    tick_nxt = ((div_r & mask) == mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule // rpd_sample_tick
`default_nettype wire

// [verilog/rpd_detector.sv]
// rotor position detector: sampling, match counting, detection pulse
// assumes pwm and timer signals come from logic on clk; position pins are asynchronous
//
// Notes on behaviour
// - status bits 5:4 hold pwm phase at last detection; 01 means pwm off
// - status bits 2:0 hold w, v, u levels when sampling last started, in either detect mode
// - config bits 7:6 pick sample period; 00 is clk/4, 10 is clk/16
// - config bits 5:4 pick condition: pwm on, always, lower phases; 11 reserved
// - config bits 3:0 set consecutive samples 1..15; 0 and 1 mean one
// - control bit 7 written 1 stops sampling; 0 does nothing; write only
// - control bit 6 written 1 starts sampling unless bit 7 is also written 1; 0 does nothing; write only
// - control bit 3 set compares only the u input, ignoring v and w
// - control bit 2 set restarts counting each pwm on period
// - after enough consecutive hits emit detection pulse and interrupt
// - codes 01 and 11 select clk/8 and clk/32
// - with recount in pwm-on sampling, count clears when pwm turns off
// - unmatch mode hits when inputs differ from the start snapshot
`timescale 1ns/1ps
`default_nettype none
module rpd_detector
  import rpd_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // register port
  input  wire logic [rpd_pkg::RPD_AW-1:0] addr,
  input  wire logic [rpd_pkg::RPD_DW-1:0] wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output var  logic [rpd_pkg::RPD_DW-1:0] rd_data,
  // position pins
  input  wire logic                      pos_input_u,
  input  wire logic                      pos_input_v,
  input  wire logic                      pos_input_w,
  // pwm and timer unit
  input  wire logic                      pwm_on,
  input  wire logic                      lower_conducting,
  input  wire logic [1:0]                pwm_phase,
  input  wire logic                      timer_b_trig,
  input  wire logic                      timer_c_trig,
  // detection
  output var  logic                      pos_detect_pulse,
  output var  logic                      position_detect_irq,
  output var  logic                      sampling_active_flag
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {pos_input_w, pos_input_v, pos_input_u};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================
  // sampling tick
  logic       tick;
  logic [1:0] sample_clock_sel;

  rpd_sample_tick u_tick (
    .clk     (clk),
    .nrst    (nrst),
    .clk_sel (sample_clock_sel),
    .tick    (tick)
  );

  // ==========================================================
  // registers
  logic [1:0] sample_clock_sel_r, sample_clock_sel_nxt;
  logic [1:0] sample_condition_sel_r, sample_condition_sel_nxt;
  logic [3:0] match_count_target_r, match_count_target_nxt;
  logic       timer_c_stop_en_r, timer_c_stop_en_nxt;
  logic       timer_b_start_en_r, timer_b_start_en_nxt;
  logic       input_count_sel_r, input_count_sel_nxt;
  logic       recount_on_pwm_en_r, recount_on_pwm_en_nxt;
  logic       detect_mode_sel_r, detect_mode_sel_nxt;
  logic [2:0] expected_r, expected_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic       ctrl_wr;

  assign sample_clock_sel = sample_clock_sel_r;
  assign ctrl_wr          = wr_en && (addr == RPD_OFS_CTRL);

  // ==========================================================
  // detection state
  rpd_state_t state_r, state_nxt;
  logic [3:0] run_cnt_r, run_cnt_nxt;
  logic [2:0] start_input_snapshot_r, start_input_snapshot_nxt;
  logic [1:0] pwm_phase_at_detect_r, pwm_phase_at_detect_nxt;
  logic       pwm_on_d_r, pwm_on_d_nxt;
  logic       detect_r, detect_nxt;
  logic       irq_r, irq_nxt;

  // compare the selected inputs against a reference
  function automatic logic inputs_equal(input logic [2:0] a, input logic [2:0] b,
                                        input logic one_pin);
    logic [2:0] m;
    m = one_pin ? RPD_MASK_ONE : RPD_MASK_THREE;
    return ((a ^ b) & m) == 3'h0;
  endfunction

  // ==========================================================
  // register next values
  always_comb begin
    sample_clock_sel_nxt     = sample_clock_sel_r;
    sample_condition_sel_nxt = sample_condition_sel_r;
    match_count_target_nxt   = match_count_target_r;
    timer_c_stop_en_nxt      = timer_c_stop_en_r;
    timer_b_start_en_nxt     = timer_b_start_en_r;
    input_count_sel_nxt      = input_count_sel_r;
    recount_on_pwm_en_nxt    = recount_on_pwm_en_r;
    detect_mode_sel_nxt      = detect_mode_sel_r;
    expected_nxt             = expected_r;
    rd_data_nxt              = RPD_UNMAPPED;
    if (wr_en) begin
      case (addr)
        RPD_OFS_CTRL: begin
          timer_c_stop_en_nxt   = wr_data[RPD_B_TC_STOP];
          timer_b_start_en_nxt  = wr_data[RPD_B_TB_START];
          input_count_sel_nxt   = wr_data[RPD_B_INPUT_CNT];
          recount_on_pwm_en_nxt = wr_data[RPD_B_RECOUNT];
          detect_mode_sel_nxt   = wr_data[RPD_B_DETECT_MD];
        end
        RPD_OFS_CFG: begin
          sample_clock_sel_nxt     = wr_data[RPD_F_CLK_HI:RPD_F_CLK_LO];
          sample_condition_sel_nxt = wr_data[RPD_F_COND_HI:RPD_F_COND_LO];
          match_count_target_nxt   = wr_data[RPD_F_CNT_HI:RPD_F_CNT_LO];
        end
        RPD_OFS_EXPECT: begin
          expected_nxt = wr_data[RPD_F_SNAP_HI:RPD_F_SNAP_LO];
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        // stop and start bits read as zero
        RPD_OFS_CTRL: begin
          rd_data_nxt[RPD_B_TC_STOP]   = timer_c_stop_en_r;
          rd_data_nxt[RPD_B_TB_START]  = timer_b_start_en_r;
          rd_data_nxt[RPD_B_INPUT_CNT] = input_count_sel_r;
          rd_data_nxt[RPD_B_RECOUNT]   = recount_on_pwm_en_r;
          rd_data_nxt[RPD_B_DETECT_MD] = detect_mode_sel_r;
        end
        RPD_OFS_CFG: begin
          rd_data_nxt = {sample_clock_sel_r, sample_condition_sel_r, match_count_target_r};
        end
        RPD_OFS_STAT: begin
          rd_data_nxt[RPD_F_PHASE_HI:RPD_F_PHASE_LO] = pwm_phase_at_detect_r;
          rd_data_nxt[RPD_B_ACTIVE]                  = (state_r == RPD_SAMPLING);
          rd_data_nxt[RPD_F_SNAP_HI:RPD_F_SNAP_LO]   = start_input_snapshot_r;
        end
        RPD_OFS_EXPECT: begin
          rd_data_nxt[RPD_F_SNAP_HI:RPD_F_SNAP_LO] = expected_r;
        end
        default: begin
          rd_data_nxt = RPD_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_clock_sel_r     <= RPD_CFG_RESET[RPD_F_CLK_HI:RPD_F_CLK_LO];
      sample_condition_sel_r <= RPD_CFG_RESET[RPD_F_COND_HI:RPD_F_COND_LO];
      match_count_target_r   <= RPD_CFG_RESET[RPD_F_CNT_HI:RPD_F_CNT_LO];
      timer_c_stop_en_r      <= 1'b0;
      timer_b_start_en_r     <= 1'b0;
      input_count_sel_r      <= 1'b0;
      recount_on_pwm_en_r    <= 1'b0;
      detect_mode_sel_r      <= 1'b0;
      expected_r             <= 3'h0;
      rd_data_r              <= RPD_UNMAPPED;
    end else begin
      sample_clock_sel_r     <= sample_clock_sel_nxt;
      sample_condition_sel_r <= sample_condition_sel_nxt;
      match_count_target_r   <= match_count_target_nxt;
      timer_c_stop_en_r      <= timer_c_stop_en_nxt;
      timer_b_start_en_r     <= timer_b_start_en_nxt;
      input_count_sel_r      <= input_count_sel_nxt;
      recount_on_pwm_en_r    <= recount_on_pwm_en_nxt;
      detect_mode_sel_r      <= detect_mode_sel_nxt;
      expected_r             <= expected_nxt;
      rd_data_r              <= rd_data_nxt;
    end
  end

  // ==========================================================
  // sampling and detection
  logic       start_ev;
  logic       stop_ev;
  logic       cond_ok;
  logic       sample;
  logic       hit;
  logic       pwm_fall;
  logic [3:0] target;
  logic [3:0] cnt_inc;

  always_comb begin
    start_ev = (ctrl_wr && wr_data[RPD_B_SW_START]) || (timer_b_start_en_r && timer_b_trig);
    stop_ev  = (ctrl_wr && wr_data[RPD_B_SW_STOP]) || (timer_c_stop_en_r && timer_c_trig);
    case (sample_condition_sel_r)
      RPD_COND_PWM_ON: cond_ok = pwm_on;
      RPD_COND_ALWAYS: cond_ok = 1'b1;
      RPD_COND_LOWER:  cond_ok = lower_conducting;
      default:         cond_ok = 1'b0;
    endcase
    sample = tick && cond_ok && (state_r == RPD_SAMPLING);
    if (detect_mode_sel_r) begin
      hit = !inputs_equal(pin_sync_r, start_input_snapshot_r, input_count_sel_r);
    end else begin
      hit = inputs_equal(pin_sync_r, expected_r, input_count_sel_r);
    end
    target   = (match_count_target_r == 4'h0) ? RPD_CNT_ONE : match_count_target_r;
    cnt_inc  = run_cnt_r + RPD_CNT_ONE;
    pwm_fall = pwm_on_d_r && !pwm_on;

    state_nxt                = state_r;
    run_cnt_nxt              = run_cnt_r;
    start_input_snapshot_nxt = start_input_snapshot_r;
    pwm_phase_at_detect_nxt  = pwm_phase_at_detect_r;
    pwm_on_d_nxt             = pwm_on;
    detect_nxt               = 1'b0;
    irq_nxt                  = 1'b0;

    if (recount_on_pwm_en_r && (sample_condition_sel_r == RPD_COND_PWM_ON) && pwm_fall) begin
      run_cnt_nxt = 4'h0;
    end

    case (state_r)
      RPD_IDLE: begin
        if (start_ev && !stop_ev) begin
          state_nxt   = RPD_SAMPLING;
          run_cnt_nxt = 4'h0;
          start_input_snapshot_nxt = pin_sync_r;
        end
      end
      RPD_SAMPLING: begin
        if (sample) begin
          if (hit && (cnt_inc >= target)) begin
            detect_nxt  = 1'b1;
            irq_nxt     = 1'b1;
            run_cnt_nxt = 4'h0;
            pwm_phase_at_detect_nxt = pwm_phase;
            state_nxt = RPD_IDLE;
          end else if (hit) begin
            run_cnt_nxt = cnt_inc;
          end else begin
            run_cnt_nxt = 4'h0;
          end
        end
        if (stop_ev && !detect_nxt) begin
          state_nxt   = RPD_IDLE;
          run_cnt_nxt = 4'h0;
        end
      end
      default: begin
        state_nxt = RPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r                <= RPD_IDLE;
      run_cnt_r              <= 4'h0;
      start_input_snapshot_r <= 3'h0;
      pwm_phase_at_detect_r  <= 2'h0;
      pwm_on_d_r             <= 1'b0;
      detect_r               <= 1'b0;
      irq_r                  <= 1'b0;
    end else begin
      state_r                <= state_nxt;
      run_cnt_r              <= run_cnt_nxt;
      start_input_snapshot_r <= start_input_snapshot_nxt;
      pwm_phase_at_detect_r  <= pwm_phase_at_detect_nxt;
      pwm_on_d_r             <= pwm_on_d_nxt;
      detect_r               <= detect_nxt;
      irq_r                  <= irq_nxt;
    end
  end

  // ==========================================================
  // outputs
  logic active_out_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_out_r <= 1'b0;
    end else begin
      active_out_r <= (state_nxt == RPD_SAMPLING);
    end
  end

  assign rd_data              = rd_data_r;
  assign pos_detect_pulse     = detect_r;
  assign position_detect_irq  = irq_r;
  assign sampling_active_flag = active_out_r;

endmodule // rpd_detector
`default_nettype wire

// [sim/rpd_detector_asserts.sv]
// checker: port-level properties of the detector
// assumes binding onto rpd_detector, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rpd_detector_chk
  import rpd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // register port
  input wire logic [12:0] addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_data,
  // detection
  input wire logic        pos_detect_pulse,
  input wire logic        position_detect_irq,
  input wire logic        sampling_active_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic ctl_wr = wr_en && addr == RPD_OFS_CTRL;
  wire logic cfg_wr = wr_en && addr == RPD_OFS_CFG;

  // ==========================================================
  // properties
  property p_irq_pair; pos_detect_pulse == position_detect_irq; endproperty
  a_irq_pair: assert property (p_irq_pair) else $error("irq differs from pulse");
  property p_pulse_one; pos_detect_pulse |=> !pos_detect_pulse; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");
  property p_flag_drop;
    pos_detect_pulse |-> !sampling_active_flag && $past(sampling_active_flag);
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("flag wrong at detection");
  property p_start;
    ctl_wr && wr_data[6] && !wr_data[7] && !sampling_active_flag |=> sampling_active_flag;
  endproperty
  a_start: assert property (p_start) else $error("start write ignored");
  property p_stop; ctl_wr && wr_data[7] |=> !sampling_active_flag; endproperty
  a_stop: assert property (p_stop) else $error("stop write ignored");
  property p_ctl_read;
    rd_en && addr == RPD_OFS_CTRL |=> rd_data[7:6] == 2'h0 && !rd_data[0];
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("write-only bits read back");
  property p_stat_flag;
    rd_en && addr == RPD_OFS_STAT |=> rd_data[3] == $past(sampling_active_flag) && rd_data[7:6] == 2'h0;
  endproperty
  a_stat_flag: assert property (p_stat_flag) else $error("status bit 3 wrong");
  property p_cfg_back;
    rd_en && addr == RPD_OFS_CFG && $past(cfg_wr, 2) && !$past(wr_en) |=> rd_data == $past(wr_data, 3);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");

  // ==========================================================
  // covers
  c_pulse: cover property (pos_detect_pulse);
  c_stop: cover property (ctl_wr && wr_data[7] && sampling_active_flag);
  c_cfg_back: cover property (rd_en && addr == RPD_OFS_CFG && $past(cfg_wr, 2));
endmodule // rpd_detector_chk

bind rpd_detector rpd_detector_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pos_detect_pulse(pos_detect_pulse),
  .position_detect_irq(position_detect_irq), .sampling_active_flag(sampling_active_flag));
`default_nettype wire

// [sim/rpd_motor_model.sv]
// motor side: position pins and a free pwm waveform
// assumes the bench sets the pin pattern and pwm run flag
`timescale 1ns/1ps
`default_nettype none
module rpd_motor_model
  import rpd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // scenario control
  input  wire logic [2:0] pattern,
  input  wire logic       pwm_run,
  // motor side
  output var  logic       pos_u,
  output var  logic       pos_v,
  output var  logic       pos_w,
  output var  logic       pwm_on,
  output var  logic       lower_conducting,
  output var  logic [1:0] pwm_phase
);
  logic [5:0] cnt_r;
  // ==========================================================
  // pwm: 40 cycles on, 40 off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 6'h00;
      pwm_on <= 1'b0;
    end else if (!pwm_run) begin
      cnt_r  <= 6'h00;
      pwm_on <= 1'b0;
    end else if (cnt_r == 6'h27) begin
      cnt_r  <= 6'h00;
      pwm_on <= !pwm_on;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  always_comb begin
    {pos_w, pos_v, pos_u} = pattern;
    lower_conducting      = !pwm_on;
    pwm_phase             = pwm_on ? 2'h0 : RPD_PHASE_OFF;
  end
endmodule // rpd_motor_model
`default_nettype wire

// [sim/rotor_position_detector_tb.sv]
// bench: register tasks, table of detection cases, hand tests
// assumes rpd_detector with motor model on its pins
`timescale 1ns/1ps
`default_nettype none
module rotor_position_detector_tb;
  import rpd_pkg::*;
  typedef struct {logic [7:0] cfg; logic [7:0] ctl; logic [2:0] ex; logic [2:0] pin; logic run; logic hit;} rpd_row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [12:0] addr = 13'h0000;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        tb_trig = 1'b0;
  logic        tc_trig = 1'b0;
  logic        run = 1'b0;
  logic [2:0]  pattern = 3'h0;
  logic [1:0]  last_ph = 2'h0;
  logic [7:0]  d;
  wire  logic [7:0] rd_data;
  wire  logic  pu, pv, pw, pwm_on, lower, pulse, irq, flag;
  wire  logic [1:0] phase;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t, dv, n;
  rpd_row_t rows[12] = '{
    '{8'h10, 8'h00, 3'h5, 3'h5, 1'b0, 1'b1}, '{8'h53, 8'h00, 3'h5, 3'h5, 1'b0, 1'b1},
    '{8'h9F, 8'h00, 3'h2, 3'h2, 1'b0, 1'b1}, '{8'hD2, 8'h00, 3'h6, 3'h6, 1'b0, 1'b1},
    '{8'h11, 8'h00, 3'h5, 3'h4, 1'b0, 1'b0}, '{8'h11, 8'h08, 3'h1, 3'h7, 1'b0, 1'b1},
    '{8'h11, 8'h02, 3'h3, 3'h3, 1'b0, 1'b0}, '{8'h31, 8'h00, 3'h3, 3'h3, 1'b0, 1'b0},
    '{8'h21, 8'h00, 3'h3, 3'h3, 1'b0, 1'b1}, '{8'h01, 8'h00, 3'h3, 3'h3, 1'b0, 1'b0},
    '{8'h0F, 8'h04, 3'h3, 3'h3, 1'b1, 1'b0}, '{8'h0F, 8'h00, 3'h3, 3'h3, 1'b1, 1'b1}};

  rpd_motor_model motor (.clk(clk), .nrst(nrst), .pattern(pattern), .pwm_run(run), .pos_u(pu),
    .pos_v(pv), .pos_w(pw), .pwm_on(pwm_on), .lower_conducting(lower), .pwm_phase(phase));
  rpd_detector dut (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pos_input_u(pu), .pos_input_v(pv), .pos_input_w(pw),
    .pwm_on(pwm_on), .lower_conducting(lower), .pwm_phase(phase), .timer_b_trig(tb_trig),
    .timer_c_trig(tc_trig), .pos_detect_pulse(pulse), .position_detect_irq(irq),
    .sampling_active_flag(flag));

  always #4 clk = !clk;

  // ==========================================================
  // tasks
  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic watch(input int lim, output int tt);
    tt = 0;
    for (int k = 1; k <= lim; k++) begin
      @(posedge clk);
      #1;
      if (pulse === 1'b1) begin
        tt = k;
        chk("irq", 8'h01, {7'h00, irq});
        break;
      end
    end
  endtask
  task automatic trig(input logic c);
    @(posedge clk);
    if (c) tc_trig <= 1'b1;
    else tb_trig <= 1'b1;
    @(posedge clk);
    tc_trig <= 1'b0;
    tb_trig <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(RPD_OFS_CFG, d); chk("cfg reset", 8'h00, d);
    rd(RPD_OFS_STAT, d); chk("stat reset", 8'h00, d);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      run <= rows[i].run;
      pattern <= rows[i].pin;
      wr(RPD_OFS_CFG, rows[i].cfg);
      rd(RPD_OFS_CFG, d); chk("cfg", rows[i].cfg, d);
      wr(RPD_OFS_EXPECT, {5'h00, rows[i].ex});
      wr(RPD_OFS_CTRL, rows[i].ctl | 8'h40);
      dv = 4 << rows[i].cfg[7:6];
      n = (rows[i].cfg[3:0] < 2) ? 1 : int'(rows[i].cfg[3:0]);
      watch((n + 2) * dv * 3 + 40, t);
      chk("detect", {7'h00, rows[i].hit}, {7'h00, t != 0});
      chk("active", {7'h00, !rows[i].hit}, {7'h00, flag});
      if (rows[i].hit && t <= (n - 1) * dv) chk("too early", 8'h00, 8'h01);
      if (rows[i].hit) last_ph = rows[i].run ? 2'h0 : RPD_PHASE_OFF;
      wr(RPD_OFS_CTRL, 8'h80);
      rd(RPD_OFS_STAT, d); chk("status", {2'h0, last_ph, 1'b0, rows[i].pin}, d);
    end
    @(posedge clk);
    run <= 1'b0;
    pattern <= 3'h6;
    wr(RPD_OFS_CFG, 8'h10);
    wr(RPD_OFS_CTRL, 8'h42);
    rd(RPD_OFS_STAT, d); chk("snapshot", {2'h0, last_ph, 1'b1, 3'h6}, d);
    @(posedge clk);
    pattern <= 3'h2;
    watch(80, t); chk("unmatch", 8'h01, {7'h00, t != 0});
    wr(RPD_OFS_CTRL, 8'h00);
    trig(1'b0); chk("trig off", 8'h00, {7'h00, flag});
    wr(RPD_OFS_CTRL, 8'h30);
    trig(1'b0); chk("trig start", 8'h01, {7'h00, flag});
    trig(1'b1); chk("trig stop", 8'h00, {7'h00, flag});
    wr(RPD_OFS_CTRL, 8'hFF);
    rd(RPD_OFS_CTRL, d); chk("ctl read", 8'h3E, d);
    chk("stop wins", 8'h00, {7'h00, flag});
    wr(RPD_OFS_CTRL, 8'h40);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1 chk("reset flag", 8'h00, {7'h00, flag});
    @(posedge clk);
    nrst <= 1'b1;
    rd(RPD_OFS_CFG, d); chk("cfg re-reset", 8'h00, d);
    rd(RPD_OFS_STAT, d); chk("stat re-reset", 8'h00, d);
    rd(13'h1FA4, d); chk("unmapped", RPD_UNMAPPED, d);
    final_report;
  end
endmodule // rotor_position_detector_tb
`default_nettype wire
